// [hw/bbtm_pkg.sv]
// shared constants and types for baseband trigger and marker control
package bbtm_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int N_MARK        = 3;
  localparam int N_CONN        = 4;
  localparam int DW            = 20;
  localparam int IW            = 16;
  localparam int MDW           = 6;
  localparam int MBUF          = 64;
  localparam int NSW           = 32;

  localparam logic [DW-1:0]  DLY_ONE    = 20'h00001;
  localparam logic [DW-1:0]  CLK_NS_DW  = 20'h00019;
  localparam logic [NSW-1:0] CLK_NS_32  = 32'h00000019;
  localparam logic [IW-1:0]  IDX_ONE    = 16'h0001;
  localparam logic [MDW-1:0] MDLY_ZERO  = 6'h00;

  typedef enum logic [4:0] {
    TM_AUTO       = 5'h01,
    TM_RETRIG     = 5'h02,
    TM_ARM_AUTO   = 5'h04,
    TM_ARM_RETRIG = 5'h08,
    TM_SINGLE     = 5'h10
  } bbtm_mode_t;

  typedef enum logic [2:0] {
    TS_INT  = 3'h1,
    TS_EXT  = 3'h2,
    TS_SYNC = 3'h4
  } bbtm_src_t;

  typedef enum logic [3:0] {
    MM_OFF                      = 4'h1,
    MM_CONTROL_LIST_MARKER_MODE = 4'h2,
    MM_START                    = 4'h4,
    MM_PERIOD                   = 4'h8
  } bbtm_mmode_t;

  typedef enum logic [1:0] {
    ST_STOP = 2'h1,
    ST_RUN  = 2'h2
  } bbtm_state_t;

  typedef struct packed {
    logic              mod_en;
    bbtm_mode_t        mode;
    bbtm_src_t         src;
    logic              edge_rise;
    logic              sync_out;
    logic              unit_sec;
    logic              clk_int;
    logic [DW-1:0]     dly_val;
    logic [DW-1:0]     inhibit;
    logic [DW-1:0]     sig_len;
    logic [IW-1:0]     period;
    logic [N_CONN-1:0] route_mask;
  } bbtm_cfg_t;

  typedef struct packed {
    bbtm_mmode_t    mode;
    logic [MDW-1:0] delay;
    logic [IW-1:0]  on_len;
  } bbtm_mcfg_t;
endpackage

// [hw/bbtm_marker_chan.sv]
// one marker channel: mode select and programmable delay line
`timescale 1ns/100ps
module bbtm_marker_chan
  import bbtm_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  input  wire bbtm_mcfg_t     mcfg,
  input  wire logic           gen_start,
  input  wire logic           gen_active,
  input  wire logic [IW-1:0]  samp_idx,
  input  wire logic           control_list_marker_mode_bit,
  output logic                marker_out
);
  logic [MBUF-1:0] dly_mem;
  logic [MDW-1:0]  wr_ptr;
  wire  [MDW-1:0]  rd_ptr = wr_ptr - mcfg.delay;
  logic            raw;

  // shape per marker mode
  always_comb begin
    case (mcfg.mode)
      MM_CONTROL_LIST_MARKER_MODE: raw = gen_active & control_list_marker_mode_bit;
      MM_START:                    raw = gen_start;
      MM_PERIOD:                   raw = gen_active & (samp_idx < mcfg.on_len);
      default:                     raw = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dly_mem    <= '0;
      wr_ptr     <= '0;
      marker_out <= 1'b0;
    end else begin
      dly_mem[wr_ptr] <= raw;
      wr_ptr          <= wr_ptr + MDLY_ONE_F();
      // delayed by mcfg.delay cycles plus one register cycle relative to the mode-shaped marker
      marker_out      <= (mcfg.delay == MDLY_ZERO) ? raw : dly_mem[rd_ptr];
    end
  end

  function automatic logic [MDW-1:0] MDLY_ONE_F();
    MDLY_ONE_F = {{(MDW-1){1'b0}}, 1'b1};
  endfunction

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_mark_dly;
    mcfg.delay == 6'h02 && $stable(mcfg) && raw |-> ##3 marker_out;
  endproperty
  a_mark_dly: assert property (p_mark_dly) else $error("marker delay wrong");

  property p_mark_off;
    mcfg.mode == MM_OFF && mcfg.delay == MDLY_ZERO |=> !marker_out;
  endproperty
  a_mark_off: assert property (p_mark_off) else $error("marker on while off");
endmodule

// [hw/bbtm_ctrl.sv]
// baseband trigger sequencing and marker channel control top
`timescale 1ns/100ps
module bbtm_ctrl
  import bbtm_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire bbtm_cfg_t           cfg,
  input  wire bbtm_mcfg_t [N_MARK-1:0] mcfg,
  input  wire logic                arm_cmd,
  input  wire logic                exec_trig_cmd,
  input  wire logic                ext_trig_pin,
  input  wire logic                sync_in_pin,
  input  wire logic [N_MARK-1:0]   control_list_marker_mode_bits,
  output logic                     running,
  output logic                     gen_active,
  output logic                     gen_start,
  output logic [IW-1:0]            samp_idx,
  output logic [NSW-1:0]           actual_dly_ns,
  output logic [N_CONN-1:0]        trig_route_out,
  output logic [N_MARK-1:0]        marker_out
);
  // pin synchronisers and edge history
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      ext_s1  <= ext_trig_pin;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      sync_s1 <= sync_in_pin;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  // active edge detection on the selected polarity
  wire ext_edge  = cfg.edge_rise ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3);
  wire sync_edge = cfg.edge_rise ? (sync_s2 & ~sync_s3) : (~sync_s2 & sync_s3);

  // source selection
  wire src_int  = (cfg.src == TS_INT);
  wire src_ext  = (cfg.src == TS_EXT);
  wire src_sync = (cfg.src == TS_SYNC);
  wire trig_raw = (src_int & exec_trig_cmd)
                | (src_ext & ext_edge)
                | (src_sync & sync_edge);

  // inhibit window for external triggers
  logic [DW-1:0] inh_cnt;
  wire           inh_busy = (inh_cnt != '0);
  logic          pend;
  logic [DW-1:0] dly_cnt;
  wire           trig_ok  = trig_raw & ~(src_ext & inh_busy) & ~pend;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      inh_cnt <= '0;
    end else if (trig_ok && src_ext && cfg.inhibit != '0) begin
      inh_cnt <= cfg.inhibit - DLY_ONE;
    end else if (inh_busy) begin
      inh_cnt <= inh_cnt - DLY_ONE;
    end
  end

  // delay in samples or converted from nanoseconds
  wire [DW-1:0] dly_cycles = cfg.unit_sec ? (cfg.dly_val / CLK_NS_DW) : cfg.dly_val;
  wire          dly_used   = ~src_int & (dly_cycles != '0);
  wire          trig_now   = trig_ok & ~dly_used;
  wire          trig_late  = pend & (dly_cnt == DLY_ONE);
  wire          trig_eff   = trig_now | trig_late;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pend    <= 1'b0;
      dly_cnt <= '0;
    end else if (trig_ok && dly_used) begin
      pend    <= 1'b1;
      dly_cnt <= dly_cycles;
    end else if (pend) begin
      pend    <= ~trig_late;
      dly_cnt <= dly_cnt - DLY_ONE;
    end
  end

  // applied delay reported in nanoseconds
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      actual_dly_ns <= '0;
    end else begin
      actual_dly_ns <= NSW'(dly_cycles) * CLK_NS_32;
    end
  end

  // trigger routing to connectors
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trig_route_out <= '0;
    end else begin
      trig_route_out <= trig_eff ? cfg.route_mask : '0;
    end
  end

  // generation sequencer
  bbtm_state_t   state;
  bbtm_state_t   next_state;
  logic [DW-1:0] len_cnt;

  wire can_gen     = cfg.mod_en & cfg.clk_int;
  wire mode_auto   = (cfg.mode == TM_AUTO);
  wire mode_single = (cfg.mode == TM_SINGLE);
  wire mode_armed  = (cfg.mode == TM_ARM_AUTO) | (cfg.mode == TM_ARM_RETRIG);
  wire mode_retrig = (cfg.mode == TM_RETRIG) | (cfg.mode == TM_ARM_RETRIG);
  wire arm_hit     = arm_cmd & mode_armed;
  wire len_done    = mode_single & ((len_cnt + DLY_ONE) >= cfg.sig_len);
  wire idx_wrap    = (samp_idx + IDX_ONE) >= cfg.period;
  wire go_auto     = mode_auto & (state == ST_STOP);
  wire go_trig     = ~mode_auto & trig_eff & (state == ST_STOP);
  wire restart     = mode_retrig & trig_eff & (state == ST_RUN) & ~arm_hit;
  wire start_now   = can_gen & (go_auto | go_trig | restart);
  wire idx_clear   = go_auto | restart | (go_trig & cfg.sync_out);

  always_comb begin
    case (state)
      ST_STOP: next_state = (can_gen && (go_auto || go_trig)) ? ST_RUN : ST_STOP;
      ST_RUN: begin
        if (!can_gen || arm_hit || (len_done && !restart)) begin
          next_state = ST_STOP;
        end else begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_STOP;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= ST_STOP;
    end else begin
      state <= next_state;
    end
  end

  // single shot sample counter
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      len_cnt <= '0;
    end else if (start_now) begin
      len_cnt <= '0;
    end else if (state == ST_RUN) begin
      len_cnt <= len_cnt + DLY_ONE;
    end
  end

  // signal sample index, wrapping at the period
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      samp_idx <= '0;
    end else if (start_now && idx_clear) begin
      samp_idx <= '0;
    end else if (next_state == ST_RUN || state == ST_RUN) begin
      samp_idx <= idx_wrap ? '0 : samp_idx + IDX_ONE;
    end
  end

  // status outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gen_start <= 1'b0;
      running   <= 1'b0;
    end else begin
      gen_start <= start_now;
      running   <= cfg.mod_en & (next_state == ST_RUN);
    end
  end

  assign gen_active = (state == ST_RUN);

  // marker channels
  genvar g;
  generate
    for (g = 0; g < N_MARK; g++) begin : g_mark
      bbtm_marker_chan u_mark (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .mcfg       (mcfg[g]),
        .gen_start  (gen_start),
        .gen_active (gen_active),
        .samp_idx   (samp_idx),
        .control_list_marker_mode_bit  (control_list_marker_mode_bits[g]),
        .marker_out (marker_out[g])
      );
    end
  endgenerate

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_int_only;
    src_int && trig_ok |-> exec_trig_cmd;
  endproperty
  a_int_only: assert property (p_int_only) else $error("internal trigger without command");

  property p_inhibit;
    trig_ok && src_ext && cfg.inhibit > 20'h00002 && $stable(cfg) |=> !trig_ok [*2];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("trigger inside inhibit");

  property p_delay;
    trig_ok && src_ext && dly_cycles == 20'h00003 && $stable(cfg) |-> ##3 trig_eff;
  endproperty
  a_delay: assert property (p_delay) else $error("delayed trigger late or early");

  property p_arm;
    arm_hit && state == ST_RUN |=> state == ST_STOP && !running;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not halt");

  property p_single;
    state == ST_RUN && len_done && !restart |=> state == ST_STOP;
  endproperty
  a_single: assert property (p_single) else $error("single shot overran");

  property p_auto;
    mode_auto && can_gen && state == ST_STOP |=> state == ST_RUN ##1 running;
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode not running");

  property p_restart;
    restart && can_gen |=> samp_idx == '0 && gen_start;
  endproperty
  a_restart: assert property (p_restart) else $error("retrigger did not restart");

  property p_sync_align;
    go_trig && can_gen && cfg.sync_out |=> samp_idx == '0;
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("start not aligned");

  property p_clk_src;
    !cfg.clk_int |=> state == ST_STOP;
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("ran without internal clock");

  property p_route;
    trig_eff |=> trig_route_out == $past(cfg.route_mask);
  endproperty
  a_route: assert property (p_route) else $error("trigger not routed");

  property p_dly_ns;
    $stable(cfg) |=> actual_dly_ns == NSW'(dly_cycles) * CLK_NS_32;
  endproperty
  a_dly_ns: assert property (p_dly_ns) else $error("reported delay wrong");

  property p_status;
    running == gen_active;
  endproperty
  a_status: assert property (p_status) else $error("status does not follow generation");

  property p_ext_edge;
    $past(rst_b) && (cfg.edge_rise ? $rose(ext_trig_pin) : $fell(ext_trig_pin)) ##1
      (ext_trig_pin == cfg.edge_rise) && $stable(cfg) |-> ##1 ext_edge;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge missed");

  property p_sync_edge;
    $past(rst_b) && (cfg.edge_rise ? $rose(sync_in_pin) : $fell(sync_in_pin)) ##1
      (sync_in_pin == cfg.edge_rise) && $stable(cfg) |-> ##1 sync_edge;
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync edge missed");

  property p_int_no_dly;
    src_int && trig_ok |-> trig_eff;
  endproperty
  a_int_no_dly: assert property (p_int_no_dly) else $error("internal trigger delayed");

  property p_unit;
    cfg.unit_sec ? (dly_cycles * CLK_NS_DW <= cfg.dly_val
                    && cfg.dly_val - dly_cycles * CLK_NS_DW < CLK_NS_DW)
                 : (dly_cycles == cfg.dly_val);
  endproperty
  a_unit: assert property (p_unit) else $error("delay unit misread");

  property p_route_idle;
    !trig_eff |=> trig_route_out == '0;
  endproperty
  a_route_idle: assert property (p_route_idle) else $error("route without trigger");

  property p_auto_free;
    mode_auto && gen_active |=> !gen_start;
  endproperty
  a_auto_free: assert property (p_auto_free) else $error("auto mode restarted");

  property p_single_len;
    mode_single && gen_active && cfg.sig_len != '0 && $stable(cfg) |-> len_cnt < cfg.sig_len;
  endproperty
  a_single_len: assert property (p_single_len) else $error("single shot too long");

  property p_arm_hold;
    mode_armed && !gen_active && !trig_eff |=> !gen_active;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("armed start without trigger");

  c_single: cover property (mode_single && go_trig ##[1:40] state == ST_STOP);
  c_retrig: cover property (restart);
  c_ext_dly: cover property (trig_late && src_ext);
  c_sync: cover property (src_sync && trig_eff);
  c_arm: cover property (arm_hit && state == ST_RUN);
endmodule

// [bench/bbtm_trig_src.sv]
// external trigger source and primary sync model
`timescale 1ns/100ps
module bbtm_trig_src (
  input  wire logic core_clk,
  input  wire logic edge_rise,
  input  wire logic fire_ext,
  input  wire logic fire_sync,
  output logic      ext_trig_pin,
  output logic      sync_in_pin
);
  logic [2:0] ext_cnt;
  logic [2:0] sync_cnt;
  initial begin
    ext_cnt = 3'h0;
    sync_cnt = 3'h0;
  end
  // four-cycle pulse at the active level, inactive level otherwise
  always @(posedge core_clk) begin
    ext_cnt <= fire_ext ? 3'h4 : ((ext_cnt != 3'h0) ? ext_cnt - 3'h1 : 3'h0);
    sync_cnt <= fire_sync ? 3'h4 : ((sync_cnt != 3'h0) ? sync_cnt - 3'h1 : 3'h0);
  end
  assign ext_trig_pin = (ext_cnt != 3'h0) ~^ edge_rise;
  assign sync_in_pin  = (sync_cnt != 3'h0) ~^ edge_rise;
endmodule

// [bench/testbench.sv]
// self-checking bench for trigger and marker control
`timescale 1ns/100ps
module testbench;
  import bbtm_pkg::*;
  logic                    core_clk, rst_b, arm_cmd, exec_trig_cmd, fire_ext, fire_sync;
  bbtm_cfg_t               cfg, nc;
  bbtm_mcfg_t [N_MARK-1:0] mcfg;
  logic [N_MARK-1:0]       control_list_marker_mode_bits, marker_out;
  logic                    running, gen_active, gen_start, ext_trig_pin, sync_in_pin;
  logic [IW-1:0]           samp_idx;
  logic [NSW-1:0]          actual_dly_ns;
  logic [N_CONN-1:0]       trig_route_out;
  logic [N_MARK-1:0]       clq[$];
  int                      miscompares, checks_done, lat, base, n, d;
  int                      t[N_MARK];

  bbtm_ctrl i_bbtm_ctrl (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .mcfg(mcfg),
    .arm_cmd(arm_cmd), .exec_trig_cmd(exec_trig_cmd), .ext_trig_pin(ext_trig_pin),
    .sync_in_pin(sync_in_pin), .control_list_marker_mode_bits(control_list_marker_mode_bits), .running(running),
    .gen_active(gen_active), .gen_start(gen_start), .samp_idx(samp_idx),
    .actual_dly_ns(actual_dly_ns), .trig_route_out(trig_route_out),
    .marker_out(marker_out));
  bbtm_trig_src i_bbtm_trig_src (.core_clk(core_clk), .edge_rise(cfg.edge_rise),
    .fire_ext(fire_ext), .fire_sync(fire_sync), .ext_trig_pin(ext_trig_pin),
    .sync_in_pin(sync_in_pin));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk_bit(input logic a, input logic e);
    checks_done++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] a, input logic [31:0] e);
    checks_done++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // reset with new configuration applied underneath
  task automatic restart;
    @(posedge core_clk);
    rst_b <= 1'b0;
    cfg <= nc;
    cyc(2);
    @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(2);
  endtask
  // 0 manual command, 1 external pin, 2 sync pin
  task automatic fire(input int w);
    @(posedge core_clk);
    if (w == 0) exec_trig_cmd <= 1'b1;
    else if (w == 1) fire_ext <= 1'b1;
    else fire_sync <= 1'b1;
    @(posedge core_clk);
    exec_trig_cmd <= 1'b0;
    fire_ext <= 1'b0;
    fire_sync <= 1'b0;
    #1;
  endtask
  task automatic wait_start(output int l);
    l = 0;
    while (gen_start !== 1'b1 && l < 200) begin
      cyc(1);
      l++;
    end
  endtask

  initial begin
    #(25 * 20000);
    miscompares++;
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    arm_cmd = 1'b0;
    exec_trig_cmd = 1'b0;
    fire_ext = 1'b0;
    fire_sync = 1'b0;
    control_list_marker_mode_bits = 3'h0;
    void'($urandom(65));
    nc.mod_en = 1'b1;
    nc.mode = TM_RETRIG;
    nc.src = TS_INT;
    nc.edge_rise = 1'b1;
    nc.sync_out = 1'b1;
    nc.unit_sec = 1'b0;
    nc.clk_int = 1'b1;
    nc.dly_val = 20'h00000;
    nc.inhibit = 20'h00014;
    nc.sig_len = DW'($urandom_range(5, 20));
    nc.period = 16'h0100;
    nc.route_mask = N_CONN'($urandom_range(1, 15));
    cfg = nc;
    for (int i = 0; i < N_MARK; i++) begin
      mcfg[i].mode = MM_START;
      mcfg[i].delay = (i == 0) ? MDLY_ZERO : MDW'($urandom_range(1, 30));
      mcfg[i].on_len = 16'h0004;
    end
    restart();
    // manual trigger, routing, aligned start, restart from the beginning
    fire(0);
    wait_start(lat);
    chk_bit(lat < 3, 1'b1);
    chk_word(32'(trig_route_out), 32'(nc.route_mask));
    chk_word(32'(samp_idx), 32'h00000000);
    chk_bit(running, 1'b1);
    cyc(1);
    chk_word(32'(samp_idx), 32'h00000001);
    for (int i = 0; i < N_MARK; i++) t[i] = -1;
    for (int c = 0; c < 90; c++) begin
      for (int i = 0; i < N_MARK; i++) if (marker_out[i] === 1'b1 && t[i] < 0) t[i] = c;
      cyc(1);
    end
    for (int i = 1; i < N_MARK; i++) chk_word(32'(t[i] - t[0]), 32'(mcfg[i].delay));
    fire(0);
    wait_start(lat);
    chk_word(32'(samp_idx), 32'h00000000);
    // arm halts until the next trigger
    nc.mode = TM_ARM_RETRIG;
    restart();
    fire(0);
    wait_start(lat);
    @(posedge core_clk);
    arm_cmd <= 1'b1;
    @(posedge core_clk);
    arm_cmd <= 1'b0;
    cyc(12);
    chk_bit(running, 1'b0);
    chk_bit(gen_active, 1'b0);
    fire(0);
    wait_start(lat);
    chk_bit(lat < 3, 1'b1);
    // armed auto waits for a trigger, then ignores further ones
    nc.mode = TM_ARM_AUTO;
    restart();
    chk_bit(gen_active, 1'b0);
    fire(0);
    wait_start(lat);
    chk_bit(lat < 3, 1'b1);
    fire(0);
    wait_start(lat);
    chk_bit(lat == 200, 1'b1);
    chk_bit(gen_active, 1'b1);
    // free running ignores the manual command
    nc.mode = TM_AUTO;
    restart();
    cyc(5);
    chk_bit(gen_active, 1'b1);
    chk_bit(running, 1'b1);
    fire(0);
    wait_start(lat);
    chk_bit(lat == 200, 1'b1);
    // control list markers follow the list states
    @(posedge core_clk);
    for (int i = 0; i < N_MARK; i++) mcfg[i].mode <= MM_CONTROL_LIST_MARKER_MODE;
    for (int i = 0; i < N_MARK; i++) mcfg[i].delay <= MDLY_ZERO;
    cyc(3);
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      control_list_marker_mode_bits <= N_MARK'($urandom);
      #1;
      if (i > 1) chk_word(32'(marker_out), 32'(clq.pop_front()));
      else if (i == 1) void'(clq.pop_front());
      clq.push_back(control_list_marker_mode_bits);
    end
    // periodic marker follows the sample index, off marker stays low
    @(posedge core_clk);
    mcfg[0].mode <= MM_PERIOD;
    mcfg[1].mode <= MM_OFF;
    cyc(2);
    for (int i = 0; i < 260; i++) begin
      base = samp_idx;
      cyc(1);
      chk_bit(marker_out[0], base < int'(mcfg[0].on_len));
      chk_bit(marker_out[1], 1'b0);
    end
    // external clock source stops generation
    nc.clk_int = 1'b0;
    restart();
    cyc(5);
    chk_bit(gen_active, 1'b0);
    nc.clk_int = 1'b1;
    // single shot runs the programmed length then stops
    nc.mode = TM_SINGLE;
    restart();
    fire(0);
    wait_start(lat);
    n = 0;
    while (gen_active === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk_word(32'(n), 32'(nc.sig_len));
    chk_bit(running, 1'b0);
    // delay in samples and in time, external source on rising edges, sync source on falling edges
    nc.mode = TM_RETRIG;
    for (int k = 0; k < 4; k++) begin
      nc.src = k[0] ? TS_SYNC : TS_EXT;
      nc.edge_rise = ~k[0];
      nc.unit_sec = k[1];
      nc.dly_val = 20'h00000;
      restart();
      fire(k[0] ? 2 : 1);
      wait_start(base);
      d = $urandom_range(1, 30);
      nc.dly_val = k[1] ? DW'(d * 25 + $urandom_range(0, 24)) : DW'(d);
      restart();
      fire(k[0] ? 2 : 1);
      wait_start(lat);
      chk_word(32'(lat - base), 32'(d));
      chk_word(actual_dly_ns, 32'(d * 25));
    end
    // external inhibit refuses an early second edge
    nc.src = TS_EXT;
    nc.edge_rise = 1'b1;
    nc.dly_val = 20'h00000;
    restart();
    fire(1);
    wait_start(lat);
    cyc(4);
    fire(1);
    wait_start(lat);
    chk_bit(lat == 200, 1'b1);
    fire(1);
    wait_start(lat);
    chk_bit(lat < 10, 1'b1);
    final_report();
  end
endmodule
